// [lpwvm_pkg.sv]
package lpwvm_pkg;

    // ========================================================================
    // Register map.
    localparam logic [7:0] LPWVM_ADDR_CFG = 8'h00;
    localparam logic [7:0] LPWVM_ADDR_STAT = 8'h04;
    localparam logic [7:0] LPWVM_ADDR_PWU_CTL = 8'h08;
    localparam logic [7:0] LPWVM_ADDR_PWU_CNT = 8'h0C;

    // ========================================================================
    // Configuration register fields.
    localparam int LPWVM_CFG_W = 6;
    localparam int CFG_SHORT_RECOVERY = 0;
    localparam int CFG_MON_PWR_DISABLE = 1;
    localparam int CFG_MON_RST_DISABLE = 2;
    localparam int CFG_MON_STOP_ENABLE = 3;
    localparam int CFG_TRIP_SELECT = 4;
    localparam int CFG_OSC_ON_IN_STOP = 5;
    localparam logic [LPWVM_CFG_W-1:0] LPWVM_CFG_RST = 6'h00;

    // ========================================================================
    // Wake-up counter control fields.
    localparam int PWU_EN_BIT = 0;
    localparam int PWU_IE_BIT = 1;
    localparam int PWU_FLAG_BIT = 31;
    localparam int PWU_PER_LO = 8;
    localparam int PWU_W = 16;
    localparam logic [PWU_W-1:0] LPWVM_PWU_PER_RST = 16'hFFFF;

    // ========================================================================
    // Stop recovery, in oscillator clock cycles.
    localparam int LPWVM_REC_W = 12;
    localparam int LPWVM_REC_FULL_CYC = 4096;
    localparam int LPWVM_REC_SHORT_CYC = 32;

    // ========================================================================
    // Wake sources, ordered by priority, and their vectors.
    localparam int LPWVM_SRC_N = 16;
    localparam int SRC_BRK = 0;
    localparam int SRC_IRQ = 1;
    localparam int SRC_CLKGEN = 2;
    localparam int SRC_T1_CH0 = 3;
    localparam int SRC_T1_CH1 = 4;
    localparam int SRC_T1_OVF = 5;
    localparam int SRC_T2_CH0 = 6;
    localparam int SRC_T2_OVF = 7;
    localparam int SRC_SS_RX = 8;
    localparam int SRC_SS_TX = 9;
    localparam int SRC_AS_ERR = 10;
    localparam int SRC_AS_RX = 11;
    localparam int SRC_AS_TX = 12;
    localparam int SRC_KEYPAD = 13;
    localparam int SRC_CONV = 14;
    localparam int SRC_PWU = 15;
    localparam logic [15:0] LPWVM_STOP_MASK = 16'hA003;
    localparam logic [15:0] LPWVM_VEC_RESET = 16'hFFFE;
    localparam logic [15:0] LPWVM_VEC [LPWVM_SRC_N] = '{
        16'hFFFC, 16'hFFFA, 16'hFFF8, 16'hFFF6, 16'hFFF4, 16'hFFF2, 16'hFFF0, 16'hFFEC,
        16'hFFEA, 16'hFFE8, 16'hFFE6, 16'hFFE4, 16'hFFE2, 16'hFFE0, 16'hFFDE, 16'hFFDC};

    // ========================================================================
    // Mode state and the block's whole register set.
    typedef enum logic [2:0] {ST_RESET, ST_RUN, ST_WAIT, ST_STOP, ST_RECOVER} lpwvm_mode_t;

    typedef struct packed {
        lpwvm_mode_t st;
        logic [LPWVM_CFG_W-1:0] cfg;
        logic irq_prev;
        logic trip_prev;
        logic lv_flag;
        logic lv_hold;
        logic wake_rst;
        logic [3:0] wake_idx;
        logic [LPWVM_REC_W-1:0] rec_cnt;
        logic pwu_en;
        logic pwu_ie;
        logic pwu_flag;
        logic [PWU_W-1:0] pwu_per;
        logic [PWU_W-1:0] pwu_cnt;
        logic [31:0] prdata;
        logic slverr;
        logic [15:0] vec;
        logic vec_vld;
        logic chip_rst;
    } lpwvm_state_t;

endpackage : lpwvm_pkg

// [lpwvm_top.sv]
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/100ps

module lpwvm_top
    import lpwvm_pkg::*;
(
    // Clock and power-on reset
    input wire logic i_mclk,
    input wire logic i_srst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // External reset pin, open drain
    input wire logic i_reset_pin,
    output logic o_reset_pin,
    output logic o_reset_pin_oe,
    // Reset and wake sources
    input wire logic i_watchdog_timeout,
    input wire logic i_ext_irq_pin,
    input wire logic i_emulation_mode,
    input wire logic i_break_irq,
    input wire logic i_clkgen_irq,
    input wire logic i_keypad_irq,
    input wire logic [2:0] i_first_timer_irq,
    input wire logic [1:0] i_second_timer_irq,
    input wire logic [1:0] i_sync_serial_irq,
    input wire logic [2:0] i_async_serial_irq,
    input wire logic i_converter_irq,
    // Processor core
    input wire logic i_wait_req,
    input wire logic i_stop_req,
    output logic o_chip_reset,
    output logic o_cpu_clk_en,
    output logic o_sys_clk_en,
    output logic [15:0] o_vector,
    output logic o_vector_valid,
    // Analog comparator
    input wire logic i_below_falling,
    input wire logic i_above_rising,
    output logic o_monitor_enable,
    output logic o_trip_level_select,
    output logic o_low_voltage_flag
);

    // ========================================================================
    // Helpers.
    function automatic logic [3:0] first_src(input logic [LPWVM_SRC_N-1:0] req);
        logic [3:0] idx;
        idx = 4'h0;
        for (int k = LPWVM_SRC_N - 1; k >= 0; k--)
        begin
            if (req[k])
            begin
                idx = 4'(k);
            end
        end
        return idx;
    endfunction : first_src

    localparam logic [LPWVM_REC_W-1:0] REC_FULL_LD = LPWVM_REC_W'(LPWVM_REC_FULL_CYC - 1);
    localparam logic [LPWVM_REC_W-1:0] REC_SHORT_LD = LPWVM_REC_W'(LPWVM_REC_SHORT_CYC - 1);

    lpwvm_state_t q;
    lpwvm_state_t d;
    logic in_stop;
    logic low_pwr;
    logic mon_on;
    logic lv_trip;
    logic rst_src;
    logic irq_fall;
    logic pwu_run;
    logic pwu_blk;
    logic [LPWVM_SRC_N-1:0] req;
    logic [LPWVM_SRC_N-1:0] wake;
    logic [3:0] pick;

    // ========================================================================
    // Next-state logic.
    always_comb
    begin
        d = q;
        d.vec_vld = 1'b0;
        in_stop = (q.st == ST_STOP);
        low_pwr = in_stop || (q.st == ST_WAIT);
        // The monitor never yields an interrupt, only reset and flag.
        mon_on = !q.cfg[CFG_MON_PWR_DISABLE] && (!in_stop || q.cfg[CFG_MON_STOP_ENABLE]);
        if (mon_on)
        begin
            if (i_below_falling)
            begin
                d.lv_flag = 1'b1;
            end
            else if (i_above_rising)
            begin
                d.lv_flag = 1'b0;
            end
        end
        d.trip_prev = q.cfg[CFG_TRIP_SELECT];
        lv_trip = mon_on && !q.cfg[CFG_MON_RST_DISABLE]
            && (i_below_falling || (q.cfg[CFG_TRIP_SELECT] && !q.trip_prev && !i_above_rising));
        if (lv_trip)
        begin
            d.lv_hold = 1'b1;
        end
        else if (i_above_rising)
        begin
            d.lv_hold = 1'b0;
        end
        // The watchdog has no clock in stop, so it cannot end stop.
        rst_src = (!i_reset_pin && !q.lv_hold) || (i_watchdog_timeout && !in_stop)
            || lv_trip || q.lv_hold;
        irq_fall = q.irq_prev && !i_ext_irq_pin;
        d.irq_prev = i_ext_irq_pin;

        req = '0;
        req[SRC_BRK] = i_break_irq && i_emulation_mode;
        req[SRC_IRQ] = irq_fall;
        req[SRC_CLKGEN] = i_clkgen_irq;
        req[SRC_T1_OVF] = i_first_timer_irq[0];
        req[SRC_T1_CH1] = i_first_timer_irq[1];
        req[SRC_T1_CH0] = i_first_timer_irq[2];
        req[SRC_T2_OVF] = i_second_timer_irq[0];
        req[SRC_T2_CH0] = i_second_timer_irq[1];
        req[SRC_SS_TX] = i_sync_serial_irq[0];
        req[SRC_SS_RX] = i_sync_serial_irq[1];
        req[SRC_AS_TX] = i_async_serial_irq[0];
        req[SRC_AS_RX] = i_async_serial_irq[1];
        req[SRC_AS_ERR] = i_async_serial_irq[2];
        req[SRC_KEYPAD] = i_keypad_irq;
        req[SRC_CONV] = i_converter_irq;
        req[SRC_PWU] = q.pwu_flag && q.pwu_ie;
        wake = in_stop ? (req & LPWVM_STOP_MASK) : req;
        pick = first_src(wake);

        // APB: decode and capture in setup, act in access.
        pwu_blk = low_pwr && (i_paddr == LPWVM_ADDR_PWU_CTL || i_paddr == LPWVM_ADDR_PWU_CNT);
        if (i_psel && !i_penable)
        begin
            d.prdata = '0;
            d.slverr = pwu_blk;
            case (i_paddr)
                LPWVM_ADDR_CFG: d.prdata[LPWVM_CFG_W-1:0] = q.cfg;
                LPWVM_ADDR_STAT: d.prdata = {q.vec, 8'h00, 3'(q.st), 3'h0, q.lv_hold, q.lv_flag};
                LPWVM_ADDR_PWU_CTL: d.prdata = {q.pwu_flag, 7'h00, q.pwu_per, 6'h00,
                    q.pwu_ie, q.pwu_en};
                LPWVM_ADDR_PWU_CNT: d.prdata[PWU_W-1:0] = q.pwu_cnt;
                default: d.slverr = 1'b1;
            endcase
            if (pwu_blk)
            begin
                d.prdata = '0;
            end
        end
        if (i_psel && i_penable && i_pwrite && !q.slverr)
        begin
            case (i_paddr)
                LPWVM_ADDR_CFG: d.cfg = i_pwdata[LPWVM_CFG_W-1:0];
                LPWVM_ADDR_PWU_CTL:
                begin
                    d.pwu_en = i_pwdata[PWU_EN_BIT];
                    d.pwu_ie = i_pwdata[PWU_IE_BIT];
                    d.pwu_per = i_pwdata[PWU_PER_LO +: PWU_W];
                    if (i_pwdata[PWU_FLAG_BIT])
                    begin
                        d.pwu_flag = 1'b0;
                    end
                end
                default: d.slverr = q.slverr;
            endcase
        end

        // Wake-up counter; a rollover set beats a software clear.
        pwu_run = q.pwu_en && !(in_stop && !q.cfg[CFG_OSC_ON_IN_STOP]);
        if (pwu_run)
        begin
            if (q.pwu_cnt == q.pwu_per)
            begin
                d.pwu_cnt = '0;
                d.pwu_flag = 1'b1;
            end
            else
            begin
                d.pwu_cnt = q.pwu_cnt + 1'b1;
            end
        end

        case (q.st)
            ST_RESET:
            begin
                if (!rst_src)
                begin
                    d.st = ST_RUN;
                    d.vec = LPWVM_VEC_RESET;
                    d.vec_vld = 1'b1;
                end
            end
            ST_RUN:
            begin
                if (rst_src)
                begin
                    d.st = ST_RESET;
                end
                else if (i_stop_req)
                begin
                    d.st = ST_STOP;
                end
                else if (i_wait_req)
                begin
                    d.st = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                if (rst_src)
                begin
                    d.st = ST_RESET;
                end
                else if (|wake)
                begin
                    d.st = ST_RUN;
                    d.vec = LPWVM_VEC[pick];
                    d.vec_vld = 1'b1;
                end
            end
            ST_STOP:
            begin
                if (rst_src || (|wake))
                begin
                    d.st = ST_RECOVER;
                    d.wake_rst = rst_src;
                    d.wake_idx = pick;
                    d.rec_cnt = q.cfg[CFG_SHORT_RECOVERY] ? REC_SHORT_LD : REC_FULL_LD;
                end
            end
            ST_RECOVER:
            begin
                if (rst_src)
                begin
                    d.wake_rst = 1'b1;
                end
                if (q.rec_cnt != '0)
                begin
                    d.rec_cnt = q.rec_cnt - 1'b1;
                end
                else if (q.wake_rst || rst_src)
                begin
                    d.st = ST_RESET;
                end
                else
                begin
                    d.st = ST_RUN;
                    d.vec = LPWVM_VEC[q.wake_idx];
                    d.vec_vld = 1'b1;
                end
            end
            default: d.st = ST_RESET;
        endcase
        if (d.st == ST_RESET && q.st != ST_RESET)
        begin
            d.lv_flag = mon_on && i_below_falling;
        end
        d.chip_rst = (d.st == ST_RESET) || (d.st == ST_RECOVER && d.wake_rst);
    end

    // ========================================================================
    // State register; i_srst acts as power-on reset.
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            q <= '0;
            q.st <= ST_RESET;
            q.cfg <= LPWVM_CFG_RST;
            q.irq_prev <= 1'b1;
            q.pwu_per <= LPWVM_PWU_PER_RST;
            q.vec <= LPWVM_VEC_RESET;
            q.chip_rst <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    // ========================================================================
    // Outputs.
    assign o_prdata = q.prdata;
    assign o_pready = 1'b1;
    assign o_pslverr = q.slverr && i_psel && i_penable;
    assign o_reset_pin = 1'b0;
    assign o_reset_pin_oe = q.lv_hold;
    assign o_chip_reset = q.chip_rst;
    assign o_cpu_clk_en = (q.st == ST_RUN);
    assign o_sys_clk_en = (q.st == ST_RUN) || (q.st == ST_WAIT) || (q.st == ST_RESET);
    assign o_vector = q.vec;
    assign o_vector_valid = q.vec_vld;
    assign o_monitor_enable = !q.cfg[CFG_MON_PWR_DISABLE] && (q.st != ST_STOP
        || q.cfg[CFG_MON_STOP_ENABLE]);
    assign o_trip_level_select = q.cfg[CFG_TRIP_SELECT];
    assign o_low_voltage_flag = q.lv_flag;

    // ========================================================================
    // Checks.
    logic [12:0] rec_len_q;
    always_ff @(posedge i_mclk)
    begin
        if (i_srst || q.st != ST_RECOVER)
        begin
            rec_len_q <= 13'h0001;
        end
        else
        begin
            rec_len_q <= rec_len_q + 13'h0001;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);

    reset_vector_a: assert property (o_vector_valid && $past(q.st) == ST_RESET
        |-> o_vector == 16'hFFFE) else $error("reset release without reset vector");
    irq_wake_a: assert property (q.st == ST_WAIT && !rst_src && irq_fall && !req[SRC_BRK]
        |=> o_vector_valid && o_vector == 16'hFFFA) else $error("irq pin wake vector wrong");
    short_rec_a: assert property (q.st == ST_RECOVER && d.st != ST_RECOVER
        && q.cfg[CFG_SHORT_RECOVERY] && $stable(q.cfg) |-> rec_len_q == 13'h0020)
        else $error("short recovery not 32 cycles");
    full_rec_a: assert property (q.st == ST_RECOVER && d.st != ST_RECOVER
        && !q.cfg[CFG_SHORT_RECOVERY] && $stable(q.cfg) |-> rec_len_q == 13'h1000)
        else $error("full recovery not 4096 cycles");
    stop_clk_a: assert property (q.st inside {ST_STOP, ST_RECOVER} |-> !o_sys_clk_en)
        else $error("system clock running in stop");
    stop_only_a: assert property (q.st == ST_STOP && !rst_src && (wake == '0)
        |=> q.st == ST_STOP) else $error("stop left without allowed source");
    flag_set_a: assert property (mon_on && i_below_falling |=> o_low_voltage_flag)
        else $error("low voltage flag not set");
    flag_clr_a: assert property (mon_on && !i_below_falling && i_above_rising
        |=> !o_low_voltage_flag) else $error("low voltage flag not cleared");
    lv_pin_a: assert property (lv_trip |=> o_reset_pin_oe ##1 o_chip_reset)
        else $error("low voltage reset not driven");
    pwu_frozen_a: assert property (q.st == ST_STOP && !q.cfg[CFG_OSC_ON_IN_STOP]
        |=> $stable(q.pwu_cnt)) else $error("wake-up counter ran in stop");
    pwu_block_a: assert property (i_psel && !i_penable && low_pwr && pwu_blk
        |=> o_pslverr) else $error("wake-up register reachable in low power");
    rst_first_a: assert property (q.st == ST_WAIT && rst_src && (wake != '0)
        |=> q.st == ST_RESET) else $error("interrupt beat reset");

    wait_wake_c: cover property (q.st == ST_WAIT ##1 o_vector_valid);
    stop_wake_c: cover property (q.st == ST_RECOVER ##1 q.st == ST_RUN);
    lv_hold_c: cover property (q.lv_hold ##1 !q.lv_hold);
    pwu_wake_c: cover property (q.st == ST_STOP && wake[SRC_PWU]);

endmodule : lpwvm_top

// [lpwvm_core_model.sv]
`timescale 1ns/100ps

// ============================================================================
// Core side: turns a bench command into a one-cycle wait or stop request.
// A request is issued only while the core clock runs, as a real core would.
module lpwvm_core_model (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_srst,
    // Commands from the bench
    input wire logic i_go_wait,
    input wire logic i_go_stop,
    // From the block
    input wire logic i_cpu_clk_en,
    // To the block
    output logic o_wait_req,
    output logic o_stop_req
);
    logic wait_q;
    logic stop_q;

    always_ff @(posedge i_mclk)
    begin
        o_wait_req <= 1'b0;
        o_stop_req <= 1'b0;
        if (i_srst)
        begin
            wait_q <= 1'b0;
            stop_q <= 1'b0;
        end
        else if (i_cpu_clk_en && (wait_q || stop_q))
        begin
            o_wait_req <= wait_q;
            o_stop_req <= stop_q;
            wait_q <= 1'b0;
            stop_q <= 1'b0;
        end
        else
        begin
            wait_q <= wait_q | i_go_wait;
            stop_q <= stop_q | i_go_stop;
        end
    end
endmodule : lpwvm_core_model

// [lpwvm_top_test.sv]
`timescale 1ns/100ps

module lpwvm_top_test;
    import lpwvm_pkg::*;

    typedef struct packed {logic [3:0] b; logic [15:0] v;} lpwvm_row_t;

    logic i_mclk, i_srst, i_psel, i_penable, i_pwrite, i_watchdog_timeout;
    logic [7:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, r;
    logic o_pready, o_pslverr, o_reset_pin, o_reset_pin_oe, e;
    logic i_wait_req, i_stop_req, o_chip_reset, o_cpu_clk_en, o_sys_clk_en;
    logic [15:0] o_vector;
    logic o_vector_valid, i_below_falling, i_above_rising;
    logic o_monitor_enable, o_trip_level_select, o_low_voltage_flag;
    logic pin_drv, go_wait, go_stop, emul;
    logic [14:0] src;
    int n, errors, tests_run, cycles;
    lpwvm_row_t rows [15] = '{
        '{4'd0, 16'hFFFC}, '{4'd1, 16'hFFFA}, '{4'd2, 16'hFFF8}, '{4'd3, 16'hFFF6},
        '{4'd4, 16'hFFF4}, '{4'd5, 16'hFFF2}, '{4'd6, 16'hFFF0}, '{4'd7, 16'hFFEC},
        '{4'd8, 16'hFFEA}, '{4'd9, 16'hFFE8}, '{4'd10, 16'hFFE6}, '{4'd11, 16'hFFE4},
        '{4'd12, 16'hFFE2}, '{4'd13, 16'hFFE0}, '{4'd14, 16'hFFDE}};

    // Open-drain reset pin with pull-up.
    wire i_reset_pin = pin_drv & ~(o_reset_pin_oe & ~o_reset_pin);
    wire i_emulation_mode = emul;
    wire i_ext_irq_pin = ~src[1];
    wire i_break_irq = src[0];
    wire i_clkgen_irq = src[2];
    wire [2:0] i_first_timer_irq = {src[3], src[4], src[5]};
    wire [1:0] i_second_timer_irq = {src[6], src[7]};
    wire [1:0] i_sync_serial_irq = {src[8], src[9]};
    wire [2:0] i_async_serial_irq = {src[10], src[11], src[12]};
    wire i_keypad_irq = src[13];
    wire i_converter_irq = src[14];

    lpwvm_top DUT (.i_mclk, .i_srst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
        .o_prdata, .o_pready, .o_pslverr, .i_reset_pin, .o_reset_pin, .o_reset_pin_oe,
        .i_watchdog_timeout, .i_ext_irq_pin, .i_emulation_mode, .i_break_irq,
        .i_clkgen_irq, .i_keypad_irq, .i_first_timer_irq, .i_second_timer_irq,
        .i_sync_serial_irq, .i_async_serial_irq, .i_converter_irq, .i_wait_req,
        .i_stop_req, .o_chip_reset, .o_cpu_clk_en, .o_sys_clk_en, .o_vector,
        .o_vector_valid, .i_below_falling, .i_above_rising, .o_monitor_enable,
        .o_trip_level_select, .o_low_voltage_flag);

    lpwvm_core_model core (.i_mclk(i_mclk), .i_srst(i_srst), .i_go_wait(go_wait),
        .i_go_stop(go_stop), .i_cpu_clk_en(o_cpu_clk_en), .o_wait_req(i_wait_req),
        .o_stop_req(i_stop_req));

    initial
    begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end

    task automatic results();
        if (errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    task automatic chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1)
        begin
            errors++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask : chk

    task automatic cyc(input int k);
        repeat (k) @(posedge i_mclk);
    endtask : cyc

    // Counts edges until a vector fetch; n ends above lim if none came.
    task automatic waitv(input int lim);
        n = 0;
        forever
        begin
            @(posedge i_mclk);
            n++;
            if (o_vector_valid === 1'b1 || n > lim)
                break;
        end
    endtask : waitv

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge i_mclk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        forever
        begin
            @(posedge i_mclk);
            k++;
            if (o_pready === 1'b1 || k > 50)
                break;
        end
        r = o_prdata;
        e = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb

    task automatic mode(input logic stop);
        @(posedge i_mclk);
        go_stop <= stop;
        go_wait <= ~stop;
        @(posedge i_mclk);
        go_stop <= 1'b0;
        go_wait <= 1'b0;
        cyc(3);
    endtask : mode

    always @(posedge i_mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            results();
        end
    end

    initial
    begin
        {i_srst, pin_drv, i_above_rising, emul} = 4'hF;
        {i_psel, i_penable, i_pwrite, i_watchdog_timeout, i_below_falling} = 5'b0;
        {i_paddr, i_pwdata, src, go_wait, go_stop} = '0;
        cyc(6);
        i_srst <= 1'b0;
        waitv(10);
        chk(o_vector === 16'hFFFE, "reset vector");
        chk(o_trip_level_select === 1'b0 && o_monitor_enable === 1'b1, "defaults");
        apb(1'b0, 8'h10, 32'h0);
        chk(e === 1'b1 && r === 32'h0, "unmapped");
        for (int i = 0; i < 15; i++)
        begin
            mode(1'b0);
            chk(o_cpu_clk_en === 1'b0 && o_sys_clk_en === 1'b1, "wait clocks");
            @(posedge i_mclk);
            src[rows[i].b] <= 1'b1;
            waitv(20);
            chk(o_vector === rows[i].v, "wait wake vector");
            src <= '0;
        end
        emul <= 1'b0;
        mode(1'b0);
        src[0] <= 1'b1;
        waitv(5);
        chk(n > 5, "break ignored outside emulation");
        src <= 15'h0004;
        waitv(20);
        chk(o_vector === 16'hFFF8, "clock generator wake");
        src <= '0;
        emul <= 1'b1;
        mode(1'b1);
        src[2] <= 1'b1;
        waitv(10);
        chk(n > 10 && o_sys_clk_en === 1'b0, "stop refused");
        chk(o_monitor_enable === 1'b0, "monitor off in stop");
        src <= 15'h2000;
        waitv(4200);
        chk(n >= 4096 && n <= 4100 && o_vector === 16'hFFE0, "full recovery");
        src <= '0;
        apb(1'b1, LPWVM_ADDR_CFG, 32'h29);
        mode(1'b1);
        chk(o_monitor_enable === 1'b1, "monitor on in stop");
        src[1] <= 1'b1;
        waitv(100);
        chk(n >= 32 && n <= 36 && o_vector === 16'hFFFA, "short recovery");
        src <= '0;
        apb(1'b1, LPWVM_ADDR_PWU_CTL, 32'h4003);
        apb(1'b0, LPWVM_ADDR_PWU_CNT, 32'h0);
        chk(e === 1'b0, "counter read in run");
        mode(1'b1);
        waitv(300);
        chk(n <= 300 && o_vector === 16'hFFDC, "counter stop wake");
        apb(1'b1, LPWVM_ADDR_PWU_CTL, 32'h8000_4003);
        mode(1'b0);
        apb(1'b0, LPWVM_ADDR_PWU_CNT, 32'h0);
        chk(e === 1'b1 && r === 32'h0, "counter blocked in wait");
        waitv(300);
        chk(n <= 300 && o_vector === 16'hFFDC, "counter wait wake");
        apb(1'b1, LPWVM_ADDR_PWU_CTL, 32'h8000_4003);
        apb(1'b1, LPWVM_ADDR_CFG, 32'h01);
        mode(1'b1);
        waitv(300);
        chk(n > 300, "counter idle in stop");
        src[13] <= 1'b1;
        waitv(100);
        chk(o_vector === 16'hFFE0, "keypad stop wake");
        src <= '0;
        apb(1'b1, LPWVM_ADDR_PWU_CTL, 32'h8000_0000);
        mode(1'b1);
        pin_drv <= 1'b0;
        cyc(2);
        pin_drv <= 1'b1;
        waitv(200);
        chk(o_vector === 16'hFFFE, "pin reset from stop");
        // Full recovery again, as a crystal oscillator needs.
        apb(1'b1, LPWVM_ADDR_CFG, 32'h0);
        mode(1'b0);
        src[2] <= 1'b1;
        i_watchdog_timeout <= 1'b1;
        waitv(4);
        chk(n > 4 && o_chip_reset === 1'b1, "reset wins");
        src <= '0;
        i_watchdog_timeout <= 1'b0;
        waitv(20);
        chk(o_vector === 16'hFFFE, "watchdog vector");
        i_below_falling <= 1'b1;
        i_above_rising <= 1'b0;
        cyc(4);
        chk(o_reset_pin_oe === 1'b1 && o_chip_reset === 1'b1, "lv reset");
        chk(o_low_voltage_flag === 1'b1, "flag low");
        i_below_falling <= 1'b0;
        cyc(6);
        chk(o_reset_pin_oe === 1'b1 && o_low_voltage_flag === 1'b1, "lv hold");
        i_above_rising <= 1'b1;
        waitv(20);
        cyc(2);
        chk(o_vector === 16'hFFFE && o_reset_pin_oe === 1'b0, "lv release");
        chk(o_low_voltage_flag === 1'b0, "flag clear");
        apb(1'b1, LPWVM_ADDR_CFG, 32'h04);
        i_below_falling <= 1'b1;
        i_above_rising <= 1'b0;
        cyc(5);
        chk(o_reset_pin_oe === 1'b0 && o_chip_reset === 1'b0, "polled");
        apb(1'b0, LPWVM_ADDR_STAT, 32'h0);
        chk(r[0] === 1'b1, "flag read");
        i_below_falling <= 1'b0;
        apb(1'b1, LPWVM_ADDR_CFG, 32'h02);
        cyc(1);
        chk(o_monitor_enable === 1'b0, "monitor disabled");
        apb(1'b1, LPWVM_ADDR_CFG, 32'h10);
        cyc(3);
        chk(o_trip_level_select === 1'b1 && o_reset_pin_oe === 1'b1, "5V trip");
        i_above_rising <= 1'b1;
        waitv(20);
        chk(o_vector === 16'hFFFE, "5V release");
        i_srst <= 1'b1;
        cyc(2);
        i_srst <= 1'b0;
        cyc(2);
        chk(o_trip_level_select === 1'b0, "3V after reset");
        results();
    end
endmodule : lpwvm_top_test
